// *** design/smartcard_status_irq_buffer.sv ***
// Purpose: Card status, interrupt flags, selection and data buffer
// Assumes: Card pins and card clock are asynchronous to clk
// Notes: Open-drain card I/O, character engine counts card clocks
//
// Local design decision: the strobed register port.
`default_nettype none
// Notes on behaviour
// - Present bit follows synced presence pin
// - Rising presence with enable raises interrupt
// - Supply-ok bit follows supply range input
// - Contact bit writes only with supply ok
// - Wait timeout set on expiry, cleared on reload
// - Tx character bit only on successful send
// - Rx character bit on success or last failure
// - Parity error on last failed repetition, or any rx error with repetition off
// - Buffer-empty flag set on move to shifter
// - Supply error flag on leaving range
// - Wait timeout flag on counter expiry
// - Tx done flag on character completion
// - Rx done flag on character completion
// - Parity flag alongside tx or rx done
// - One enable per source, bit five zero
// - Guard enable rising edge loads guard counter
// - Repeat select picks four or three repeats
// - Pull-up control bit disables presence pull-up
// - Buffer written when empty, sent in convention; the code also takes writes while not empty
// - Received byte reordered into data buffer
// - Empty status set on move, cleared on write
// - Convention sets bit order and line polarity
module smartcard_status_irq_buffer
	import card_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic [card_pkg::AW-1:0] addr,
	input  wire logic [card_pkg::DW-1:0] wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	output var  logic [card_pkg::DW-1:0] rdata,
	input  wire logic                  presence_input_pin,
	input  wire logic                  supply_in_range,
	input  wire logic                  link_clk,
	input  wire logic                  card_io_in,
	output var  logic                  card_io_out,
	output var  logic                  card_io_oe,
	output var  logic                  manual_clock_out,
	output var  logic                  manual_reset_out,
	output var  logic                  presence_pullup_en,
	output var  logic                  irq
);
	import card_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [3:0]  sy1;
		logic [3:0]  sy2;
		logic        lclk3;
		logic [3:0]  ctrl;
		logic [2:0]  cont;
		logic [7:0]  sel;
		logic [7:0]  ien;
		logic [7:0]  flag;
		logic        tbe;
		logic        cin;
		logic        vok;
		logic        wto;
		logic        txc;
		logic        rxc;
		logic        pe;
		logic [7:0]  buf_byte;
		eng_t        eng;
		logic [8:0]  shf;
		logic [10:0] c;
		logic [3:0]  idx;
		logic [2:0]  tries;
		logic        err;
		logic        drv;
		logic [10:0] etu;
		logic [31:0] wt;
		logic [8:0]  bg;
		logic [7:0]  rdata;
		logic        io_oe;
		logic        clk_o;
		logic        rst_o;
		logic        pull_o;
		logic        irq;
	} st_t;
	st_t  s_q;
	st_t  s_d;
	logic etu_tick;
	// ==========================================================
	// Helpers
	function automatic logic [7:0] order8(input logic [7:0] b,
		input logic bit_order_convention);
		logic [7:0] r;
		r = b;
		if (bit_order_convention)
		begin
			for (int i = 0; i < 8; i++)
				r[i] = b[7 - i];
		end
		return r;
	endfunction
	// ==========================================================
	// Next state
	always_comb
	begin
		logic       lt;
		logic       start;
		logic       guard_ok;
		logic       fail;
		logic       linebit;
		logic [2:0] rmax;
		lt = s_q.sy2[3] & ~s_q.lclk3;
		start = 1'b0;
		fail = 1'b0;
		linebit = 1'b1;
		rmax = s_q.sel[S_RSEL] ? REP_MAX4 : REP_MAX5;
		guard_ok = !s_q.sel[S_BGT] || (s_q.bg == 9'h000);
		s_d = s_q;
		s_d.rdata = 8'h00;
		s_d.sy1 = {link_clk, card_io_in, supply_in_range,
			presence_input_pin};
		s_d.sy2 = s_q.sy1;
		s_d.lclk3 = s_q.sy2[3];
		etu_tick = lt && (s_q.etu == ETU_CLKS - 11'h001);
		if (lt)
			s_d.etu = etu_tick ? 11'h000 : s_q.etu + 11'h001;
		if (etu_tick && s_q.bg != 9'h000)
			s_d.bg = s_q.bg - 9'h001;
		// Register writes
		if (wr)
		begin
			case (addr)
				A_CTRL: s_d.ctrl = wdata[3:0];
				A_CONT:
				begin
					if (s_q.vok)
						s_d.cont = wdata[3:1];
				end
				A_STAT:
				begin
					s_d.txc = s_q.txc & ~wdata[B_TX];
					s_d.rxc = s_q.rxc & ~wdata[B_RX];
					s_d.pe = s_q.pe & ~wdata[B_PAR];
				end
				A_FLAG: s_d.flag = s_q.flag & ~wdata;
				A_IEN: s_d.ien = wdata & IEN_MASK;
				A_SEL:
				begin
					s_d.sel = wdata & SEL_MASK;
					if (wdata[S_BGT] && !s_q.sel[S_BGT])
						s_d.bg = GUARD_TIME_VALUE;
				end
				A_BUF:
				begin
					s_d.buf_byte = wdata;
					s_d.tbe = 1'b0;
				end
				default: ;
			endcase
		end
		// Register reads
		if (rd)
		begin
			case (addr)
				A_CTRL: s_d.rdata = {4'h0, s_q.ctrl};
				A_CONT: s_d.rdata = {4'h0, s_q.cont, 1'b0};
				A_STAT: s_d.rdata = {s_q.tbe, s_q.cin, 1'b0,
					s_q.vok, s_q.wto, s_q.txc, s_q.rxc, s_q.pe};
				A_FLAG: s_d.rdata = s_q.flag;
				A_IEN: s_d.rdata = s_q.ien;
				A_SEL: s_d.rdata = s_q.sel;
				A_BUF: s_d.rdata = s_q.buf_byte;
				default: s_d.rdata = 8'h00;
			endcase
		end
		// Character engine
		if (s_q.eng != ENG_IDLE && lt)
		begin
			if (s_q.c == ETU_CLKS - 11'h001)
			begin
				s_d.c = 11'h000;
				s_d.idx = s_q.idx + 4'h1;
			end
			else
				s_d.c = s_q.c + 11'h001;
		end
		case (s_q.eng)
			ENG_IDLE:
			begin
				if (s_q.ctrl[C_UART] && !s_q.tbe && guard_ok)
				begin
					s_d.shf = {^s_q.buf_byte,
						order8(s_q.buf_byte, s_q.ctrl[C_BIT_ORDER_CONVENTION])};
					s_d.tbe = 1'b1;
					s_d.flag[B_TBE] = 1'b1;
					s_d.buf_byte = 8'h00;
					s_d.tries = 3'h0;
					s_d.err = 1'b0;
					s_d.c = 11'h000;
					s_d.idx = 4'h0;
					s_d.eng = ENG_TX;
					start = 1'b1;
				end
				else if (s_q.ctrl[C_UART] && !s_q.sy2[2])
				begin
					s_d.err = 1'b0;
					s_d.c = 11'h000;
					s_d.idx = 4'h0;
					s_d.eng = ENG_RX;
					start = 1'b1;
					if (s_q.sel[S_BGT])
						s_d.bg = GUARD_TIME_VALUE;
				end
			end
			ENG_TX:
			begin
				if (lt && s_q.idx == IDX_ERR && s_q.c == ETU_HALF)
					s_d.err = ~s_q.sy2[2];
				if (s_q.idx == IDX_END)
				begin
					fail = s_q.err && s_q.ctrl[C_REP];
					if (fail && s_q.tries < rmax)
					begin
						s_d.tries = s_q.tries + 3'h1;
						s_d.err = 1'b0;
						s_d.c = 11'h000;
						s_d.idx = 4'h0;
						start = 1'b1;
					end
					else
					begin
						s_d.eng = ENG_IDLE;
						s_d.tries = 3'h0;
						s_d.flag[B_TX] = 1'b1;
						if (fail)
						begin
							s_d.pe = 1'b1;
							s_d.flag[B_PAR] = 1'b1;
						end
						else
							s_d.txc = 1'b1;
					end
				end
			end
			ENG_RX:
			begin
				if (lt && s_q.c == ETU_HALF && s_q.idx != 4'h0 &&
					s_q.idx <= IDX_DATA_END)
					s_d.shf[s_q.idx - 4'h1] =
						s_q.sy2[2] ^ s_q.ctrl[C_BIT_ORDER_CONVENTION];
				if (lt && s_q.idx == IDX_ERR && s_q.c == ETU_HALF)
					s_d.err = ^s_q.shf;
				if (s_q.idx == IDX_END)
				begin
					s_d.eng = ENG_IDLE;
					fail = s_q.err && s_q.ctrl[C_REP];
					if (fail && s_q.tries < rmax)
						s_d.tries = s_q.tries + 3'h1;
					else
					begin
						s_d.tries = 3'h0;
						s_d.buf_byte = order8(s_q.shf[7:0],
							s_q.ctrl[C_BIT_ORDER_CONVENTION]);
						s_d.rxc = 1'b1;
						s_d.flag[B_RX] = 1'b1;
						if (s_q.err)
						begin
							s_d.pe = 1'b1;
							s_d.flag[B_PAR] = 1'b1;
						end
					end
				end
			end
			default: s_d.eng = ENG_IDLE;
		endcase
		// Line drive from the next frame position
		if (s_d.eng == ENG_TX && s_d.idx <= IDX_DATA_END)
			linebit = (s_d.idx == 4'h0) ? 1'b0 :
				s_d.shf[s_d.idx - 4'h1] ^ s_q.ctrl[C_BIT_ORDER_CONVENTION];
		s_d.drv = !linebit || (s_d.eng == ENG_RX &&
			s_d.idx == IDX_SIG && s_q.err && s_q.ctrl[C_REP] &&
			s_q.tries < rmax);

		// Waiting time counter and timeout flag
		if (!s_q.ctrl[C_WTEN])
			s_d.wt = 32'h0;
		else if (start)
		begin
			s_d.wt = 32'h0;
			s_d.wto = 1'b0;
		end
		else if (etu_tick && s_q.wt != WAIT_ETUS)
		begin
			s_d.wt = s_q.wt + 32'h1;
			if (s_q.wt == WAIT_ETUS - 32'h1)
			begin
				s_d.wto = 1'b1;
				s_d.flag[B_WT] = 1'b1;
			end
		end

		// Pin status and their events
		s_d.cin = s_q.sy2[0];
		s_d.vok = s_q.sy2[1];
		if (s_q.sy2[0] && !s_q.cin)
			s_d.flag[B_INS] = 1'b1;
		if (!s_q.sy2[1] && s_q.vok)
			s_d.flag[B_VOK] = 1'b1;

		// Outputs
		s_d.io_oe = s_d.ctrl[C_UART] ? s_d.drv : ~s_d.cont[2];
		s_d.clk_o = s_d.cont[1];
		s_d.rst_o = s_d.cont[0];
		s_d.pull_o = ~s_d.sel[S_PULL];
		s_d.irq = |(s_d.flag & s_d.ien);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s_q <= '0;
			s_q.tbe <= 1'b1;
			s_q.pull_o <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign rdata = s_q.rdata;
	assign card_io_out = 1'b0;
	assign card_io_oe = s_q.io_oe;
	assign manual_clock_out = s_q.clk_o;
	assign manual_reset_out = s_q.rst_o;
	assign presence_pullup_en = s_q.pull_o;
	assign irq = s_q.irq;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence s_wr_sel;
		wr && addr == A_SEL;
	endsequence
	sequence s_bgt_rise;
		s_wr_sel ##0 (wdata[S_BGT] && !s_q.sel[S_BGT]);
	endsequence
	property p_cin;
		rd && addr == A_STAT |=> rdata[B_INS] == $past(s_q.cin);
	endproperty
	a_cin: assert property (p_cin) else $error("presence bit");
	property p_ins;
		s_q.sy2[0] && !s_q.cin && s_q.ien[B_INS] && !(wr && addr == A_IEN) |=> irq;
	endproperty
	a_ins: assert property (p_ins) else $error("insert irq");
	property p_cont;
		wr && addr == A_CONT && !s_q.vok |=> $stable(s_q.cont);
	endproperty
	a_cont: assert property (p_cont) else $error("contact");
	property p_wto;
		s_q.ctrl[C_WTEN] && etu_tick && s_q.eng == ENG_IDLE &&
		!s_q.ctrl[C_UART] && s_q.wt == WAIT_ETUS - 32'h1
		|=> s_q.wto && s_q.flag[B_WT];
	endproperty
	a_wto: assert property (p_wto) else $error("timeout");
	property p_tbe;
		wr && addr == A_BUF && s_q.tbe |=> !s_q.tbe;
	endproperty
	a_tbe: assert property (p_tbe) else $error("empty clear");
	property p_ien;
		rd && addr == A_IEN |=> !rdata[5];
	endproperty
	a_ien: assert property (p_ien) else $error("enable bit5");
	property p_irq;
		|(s_q.flag & s_q.ien) |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq level");
	property p_bgt;
		s_bgt_rise |=> s_q.bg == GUARD_TIME_VALUE;
	endproperty
	a_bgt: assert property (p_bgt) else $error("guard load");
	property p_txd;
		s_q.eng == ENG_TX && s_q.idx == IDX_END && !s_q.err |=> s_q.txc && s_q.flag[B_TX];
	endproperty
	a_txd: assert property (p_txd) else $error("tx done");
	property p_pull;
		s_wr_sel |=> presence_pullup_en == !$past(wdata[S_PULL]);
	endproperty
	a_pull: assert property (p_pull) else $error("pull-up");
endmodule
`default_nettype wire

// *** shared/card_pkg.sv ***
// Purpose: Constants for the card status, interrupt and buffer block
// Assumes: 8-bit register port, card clock sampled on clk
// Notes: Bit positions shared by status, flag and enable registers
`default_nettype none
package card_pkg;
	// ==========================================================
	// Bus and register map
	localparam int AW = 8;
	localparam int DW = 8;
	localparam logic [7:0] A_CTRL = 8'hff;
	localparam logic [7:0] A_CONT = 8'hfe;
	localparam logic [7:0] A_STAT = 8'hfd;
	localparam logic [7:0] A_FLAG = 8'hfc;
	localparam logic [7:0] A_IEN  = 8'hfb;
	localparam logic [7:0] A_SEL  = 8'hfa;
	localparam logic [7:0] A_BUF  = 8'hf9;
	// ==========================================================
	// Field positions and masks
	localparam int B_TBE  = 7;
	localparam int B_INS  = 6;
	localparam int B_VOK  = 4;
	localparam int B_WT   = 3;
	localparam int B_TX   = 2;
	localparam int B_RX   = 1;
	localparam int B_PAR  = 0;
	localparam int C_UART = 3;
	localparam int C_WTEN = 2;
	localparam int C_REP  = 1;
	localparam int C_BIT_ORDER_CONVENTION = 0;
	localparam int S_BGT  = 6;
	localparam int S_RSEL = 4;
	localparam int S_PULL = 3;
	localparam logic [7:0] IEN_MASK = 8'hdf;
	localparam logic [7:0] SEL_MASK = 8'h58;
	localparam logic [7:0] CLR_MASK = 8'h07;
	// ==========================================================
	// Timing and counts
	localparam logic [10:0] ETU_CLKS = 11'h174;
	localparam logic [10:0] ETU_HALF = 11'h0ba;
	localparam logic [8:0]  GUARD_TIME_VALUE = 9'h00c;
	localparam logic [31:0] WAIT_ETUS = 32'h00002580;
	localparam logic [2:0]  REP_MAX5 = 3'h4;
	localparam logic [2:0]  REP_MAX4 = 3'h3;
	localparam logic [3:0]  IDX_DATA_END = 4'h9;
	localparam logic [3:0]  IDX_ERR = 4'ha;
	localparam logic [3:0]  IDX_SIG = 4'hb;
	localparam logic [3:0]  IDX_END = 4'hc;
	typedef enum logic [1:0] {ENG_IDLE, ENG_TX, ENG_RX} eng_t;
endpackage
`default_nettype wire

// *** test/card_model.sv ***
// Purpose: Card side of the card I/O contact
// Assumes: Open-drain I/O line with pull-up, free-running card clock
// Notes: 372 card clocks per bit, even parity
`default_nettype none
module card_model
(
	output var  logic       link_clk,
	output var  logic       line_rel,
	input  wire logic       line,
	input  wire logic       bit_order_convention,
	input  wire logic       listen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got;
	logic       got_par;
	logic       v;
	// ==========================================================
	// Card clock
	initial
	begin
		link_clk = 1'b0;
		line_rel = 1'b1;
		got = 8'h00;
		got_par = 1'b0;
		forever #100 link_clk = ~link_clk;
	end
	task automatic etu(input int n);
		repeat (n) @(posedge link_clk);
	endtask
	// ==========================================================
	// Card sends one character, bad_par flips parity
	task automatic send(input logic [7:0] d, input logic bad_par);
		logic b;
		line_rel <= 1'b0;
		etu(372);
		for (int i = 0; i < 9; i++)
		begin
			b = (i == 8) ? (^d ^ bad_par) : (bit_order_convention ? d[7 - i] : d[i]);
			line_rel <= bit_order_convention ? ~b : b;
			etu(372);
		end
		line_rel <= 1'b1;
		etu(1116);
	endtask
	// ==========================================================
	// Card captures one character
	always
	begin
		@(negedge line iff listen);
		etu(186);
		for (int i = 0; i < 9; i++)
		begin
			etu(372);
			v = bit_order_convention ? ~line : line;
			if (i == 8)
				got_par = v;
			else
				got[bit_order_convention ? 7 - i : i] = v;
		end
	end
endmodule
`default_nettype wire

// *** test/test_smartcard_status_irq_buffer.sv ***
// Purpose: Self-checking bench of the card status and buffer block
// Assumes: Card model on the I/O line, 40 MHz clock
// Notes: One sent and one received character
`default_nettype none
module test_smartcard_status_irq_buffer;
	timeunit 1ns;
	timeprecision 1ps;
	import card_pkg::*;
	logic        clk;
	logic        reset;
	logic        wr;
	logic        rd;
	logic        pin;
	logic        sup;
	logic        link_clk;
	logic        io_oe;
	logic        mclk;
	logic        mrst;
	logic        pull;
	logic        irq;
	logic        io_out;
	logic        rel;
	logic        bit_order_convention;
	logic        listen;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic [31:0] rnd;
	int          failures;
	int          n_checks;
	int          cyc;
	wire logic   line = rel & ~io_oe;
	smartcard_status_irq_buffer smartcard_status_irq_buffer_i (.clk(clk), .reset(reset),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.presence_input_pin(pin), .supply_in_range(sup), .link_clk(link_clk),
		.card_io_in(line), .card_io_out(io_out), .card_io_oe(io_oe),
		.manual_clock_out(mclk),
		.manual_reset_out(mrst), .presence_pullup_en(pull), .irq(irq));
	card_model card_model_i (.link_clk(link_clk), .line_rel(rel), .line(line),
		.bit_order_convention(bit_order_convention), .listen(listen));
	// ==========================================================
	// Clock, timeout, helpers
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 95000)
		begin
			failures++;
			end_of_test();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic end_of_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp, what);
	endtask
	task automatic wait_irq(input int n);
		int k;
		k = 0;
		while (irq !== 1'b1 && k < n)
		begin
			@(posedge clk);
			#1 k++;
		end
		chk({7'h0, irq}, 8'h01, "irq");
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		reset = 1'b1;
		{wr, rd, pin, sup, bit_order_convention, listen} = 6'h00;
		addr = 8'h00;
		wdata = 8'h00;
		rnd = 32'h5bdb8534;
		failures = 0;
		n_checks = 0;
		cyc = 0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		rd_chk(A_STAT, 8'h80, "status");
		rd_chk(A_FLAG, 8'h00, "flags");
		rd_chk(A_IEN, 8'h00, "enables");
		rd_chk(A_SEL, 8'h00, "select");
		rd_chk(A_BUF, 8'h00, "buffer");
		rd_chk(8'h10, 8'h00, "unmapped");
		chk({7'h0, pull}, 8'h01, "pullup");
		repeat (4)
		begin
			rnd = lfsr(rnd);
			wr_reg(A_IEN, rnd[7:0]);
			rd_chk(A_IEN, rnd[7:0] & IEN_MASK, "enables");
			wr_reg(A_SEL, (rnd[15:8] & SEL_MASK) | 8'h40);
			rd_chk(A_SEL, (rnd[15:8] & SEL_MASK) | 8'h40, "select");
			chk({7'h0, pull}, {7'h0, ~rnd[8 + S_PULL]}, "pullup");
		end
		wr_reg(A_SEL, 8'h00);
		wr_reg(A_IEN, 8'h40);
		pin <= 1'b1;
		wait_irq(20);
		rd_chk(A_STAT, 8'hc0, "present");
		rd_chk(A_FLAG, 8'h40, "insert");
		wr_reg(A_FLAG, 8'h40);
		rd_chk(A_FLAG, 8'h00, "cleared");
		chk({7'h0, irq}, 8'h00, "irq off");
		pin <= 1'b0;
		wr_reg(A_CONT, 8'h0c);
		repeat (6) @(posedge clk);
		rd_chk(A_STAT, 8'h80, "absent");
		chk({7'h0, mclk}, 8'h00, "blocked");
		sup <= 1'b1;
		repeat (6) @(posedge clk);
		rd_chk(A_STAT, 8'h90, "supply");
		wr_reg(A_CONT, 8'h0e);
		repeat (2) @(posedge clk);
		#1 chk({5'h0, io_oe, mclk, mrst}, 8'h03, "contacts");
		chk({7'h0, io_out}, 8'h00, "io level");
		sup <= 1'b0;
		repeat (6) @(posedge clk);
		rd_chk(A_FLAG, 8'h10, "supply err");
		wr_reg(A_FLAG, 8'h10);
		sup <= 1'b1;
		rnd = lfsr(rnd);
		bit_order_convention <= rnd[16];
		listen <= 1'b1;
		wr_reg(A_CTRL, {7'h04, rnd[16]});
		wr_reg(A_IEN, 8'h04);
		wr_reg(A_BUF, rnd[7:0]);
		repeat (3) @(posedge clk);
		rd_chk(A_FLAG, 8'h80, "tbe flag");
		rd_chk(A_BUF, 8'h00, "buf gone");
		wait_irq(40000);
		listen <= 1'b0;
		rd_chk(A_STAT, 8'h94, "tx status");
		rd_chk(A_FLAG, 8'h84, "tx flags");
		chk(card_model_i.got, rnd[7:0], "card byte");
		chk({7'h0, card_model_i.got_par}, {7'h0, ^rnd[7:0]}, "parity");
		wr_reg(A_FLAG, 8'hff);
		wr_reg(A_STAT, 8'h07);
		rnd = lfsr(rnd);
		wr_reg(A_IEN, 8'h02);
		fork
			card_model_i.send(rnd[7:0], 1'b1);
		join_none
		wait_irq(40000);
		rd_chk(A_FLAG, 8'h03, "rx flags");
		rd_chk(A_STAT, 8'h93, "rx status");
		rd_chk(A_BUF, rnd[7:0], "rx byte");
		end_of_test();
	end
endmodule
`default_nettype wire
